// *** logic/arith_decode_pkg.sv ***
// shared types and constants of the arithmetic opcode decoder
package arith_decode_pkg;

   // ****************************************************************
   // opcode encodings
   // ****************************************************************
   localparam logic [7:0] opc_unpacked_bcd_sum_adjust = 8'h37;
   localparam logic [7:0] opc_packed_bcd_sum_adjust = 8'h27;
   localparam logic [7:0] opc_unpacked_bcd_difference_adjust = 8'h3f;
   localparam logic [7:0] opc_packed_bcd_difference_adjust = 8'h2f;
   localparam logic [2:0] fld_sum = 3'h0;
   localparam logic [2:0] fld_sum_carry = 3'h2;
   localparam logic [2:0] fld_borrow = 3'h3;
   localparam logic [2:0] fld_difference = 3'h5;
   localparam logic [2:0] fld_sign_change = 3'h3;
   localparam logic [2:0] fld_product = 3'h4;
   localparam logic [1:0] mod_register = 2'h3;
   localparam logic [1:0] mod_disp8 = 2'h1;
   localparam logic [1:0] mod_disp16 = 2'h2;
   localparam logic [1:0] mod_direct = 2'h0;
   localparam logic [2:0] rm_direct = 3'h6;

   // ****************************************************************
   // cycle budgets
   // ****************************************************************
   localparam logic [5:0] cyc_prefix = 6'd2;
   localparam logic [5:0] cyc_rm_reg = 6'd3;
   localparam logic [5:0] cyc_rm_mem = 6'd10;
   localparam logic [5:0] cyc_imm_reg = 6'd4;
   localparam logic [5:0] cyc_imm_mem = 6'd16;
   localparam logic [5:0] cyc_acc_byte = 6'd3;
   localparam logic [5:0] cyc_acc_word = 6'd4;
   localparam logic [5:0] cyc_unpacked_sum_adj = 6'd8;
   localparam logic [5:0] cyc_packed_adj = 6'd4;
   localparam logic [5:0] cyc_unpacked_diff_adj = 6'd7;
   localparam logic [5:0] cyc_prod_reg_byte_min = 6'd26;
   localparam logic [5:0] cyc_prod_reg_byte_max = 6'd28;
   localparam logic [5:0] cyc_prod_reg_word_min = 6'd35;
   localparam logic [5:0] cyc_prod_reg_word_max = 6'd37;
   localparam logic [5:0] cyc_prod_mem_byte_min = 6'd32;
   localparam logic [5:0] cyc_prod_mem_byte_max = 6'd34;
   localparam logic [5:0] cyc_prod_mem_word_min = 6'd41;
   localparam logic [5:0] cyc_prod_mem_word_max = 6'd43;
   localparam logic [5:0] cyc_narrow_per_xfer = 6'd4;

   // ****************************************************************
   // types
   // ****************************************************************
   typedef enum logic [3:0] {
      op_unsupported = 4'h0,
      op_sum = 4'h1,
      op_sum_carry = 4'h2,
      op_difference = 4'h3,
      difference_with_borrow_op = 4'h4,
      sign_change_op = 4'h5,
      unsigned_product_op = 4'h6,
      unpacked_bcd_sum_adjust = 4'h7,
      packed_bcd_sum_adjust = 4'h8,
      unpacked_bcd_difference_adjust = 4'h9,
      packed_bcd_difference_adjust = 4'ha,
      op_segment_prefix = 4'hb
   } op_t;

   typedef enum logic [2:0] {
      form_single = 3'h0,
      form_rm_reg = 3'h1,
      form_imm_rm = 3'h2,
      form_imm_acc = 3'h3,
      form_unary_rm = 3'h4
   } form_t;

   // segment codes: extra, code, stack, data
   typedef enum logic [1:0] {
      extra_segment_prefix = 2'h0,
      code_segment_prefix = 2'h1,
      stack_segment_prefix = 2'h2,
      data_segment_prefix = 2'h3
   } seg_t;

   typedef struct packed {
      op_t op;
      form_t form;
      logic wide;
      logic dir;
      logic sign;
      logic [1:0] mode;
      logic [2:0] reg_fld;
      logic [2:0] rm;
      logic mem;
      logic seg_valid;
      seg_t seg;
      logic [15:0] disp;
      logic [15:0] imm;
      logic [5:0] cyc_min;
      logic [5:0] cyc_max;
   } dec_t;

   typedef enum logic [2:0] {
      st_opcode = 3'b000,
      st_modrm = 3'b001,
      st_disp_lo = 3'b011,
      st_disp_hi = 3'b010,
      st_imm_lo = 3'b110,
      st_imm_hi = 3'b111,
      st_cost = 3'b101,
      st_emit = 3'b100
   } state_t;

endpackage

// *** logic/arith_cost_lookup.sv ***
// cycle budget table for one decoded arithmetic operation
`timescale 1ns/1ps
module arith_cost_lookup
   import arith_decode_pkg::*;
(
   // decoded operation
   input wire arith_decode_pkg::op_t i_op,
   input wire arith_decode_pkg::form_t i_form,
   input wire logic i_wide,
   input wire logic i_dir,
   input wire logic i_mem,
   // bus variant
   input wire logic i_narrow_bus,
   // budget
   output logic [5:0] o_cyc_min,
   output logic [5:0] o_cyc_max
);
   import arith_decode_pkg::*;

   logic [5:0] base_min;
   logic [5:0] base_max;
   logic [1:0] xfers;
   logic [5:0] extra;

   always_comb
   begin
      base_min = 6'h00;
      xfers = 2'h0;
      unique case (i_op)
         op_segment_prefix: base_min = cyc_prefix;
         unpacked_bcd_sum_adjust: base_min = cyc_unpacked_sum_adj;
         packed_bcd_sum_adjust: base_min = cyc_packed_adj;
         unpacked_bcd_difference_adjust:
            base_min = cyc_unpacked_diff_adj;
         packed_bcd_difference_adjust: base_min = cyc_packed_adj;
         unsigned_product_op:
         begin
            unique case ({i_mem, i_wide})
               2'b00: base_min = cyc_prod_reg_byte_min;
               2'b01: base_min = cyc_prod_reg_word_min;
               2'b10: base_min = cyc_prod_mem_byte_min;
               default: base_min = cyc_prod_mem_word_min;
            endcase
            xfers = 2'h1;
         end
         op_unsupported: base_min = 6'h00;
         default:
         begin
            unique case (i_form)
               form_imm_acc:
                  base_min = i_wide ? cyc_acc_word : cyc_acc_byte;
               form_imm_rm:
                  base_min = i_mem ? cyc_imm_mem : cyc_imm_reg;
               default:
                  base_min = i_mem ? cyc_rm_mem : cyc_rm_reg;
            endcase
            // read-modify-write costs two transfers, a load only one
            if (i_form == form_rm_reg && i_dir)
               xfers = 2'h1;
            else if (i_form != form_imm_acc)
               xfers = 2'h2;
         end
      endcase
   end

   always_comb
   begin
      base_max = base_min;
      if (i_op == unsigned_product_op)
      begin
         unique case ({i_mem, i_wide})
            2'b00: base_max = cyc_prod_reg_byte_max;
            2'b01: base_max = cyc_prod_reg_word_max;
            2'b10: base_max = cyc_prod_mem_byte_max;
            default: base_max = cyc_prod_mem_word_max;
         endcase
      end
   end

   // word memory operands on the narrow bus pay per transfer
   always_comb
   begin
      extra = 6'h00;
      if (i_narrow_bus && i_mem && i_wide)
         extra = (xfers == 2'h2) ? 6'(2 * cyc_narrow_per_xfer)
               : (xfers == 2'h1) ? cyc_narrow_per_xfer : 6'h00;
   end

   assign o_cyc_min = 6'(base_min + extra);
   assign o_cyc_max = 6'(base_max + extra);

endmodule

// *** logic/arith_opcode_decoder.sv ***
// byte-serial decoder for segment prefixes and integer arithmetic opcodes
`timescale 1ns/1ps

module arith_opcode_decoder
   import arith_decode_pkg::*;
(
   // clock and reset
   input wire logic i_clock,
   input wire logic i_nrst,
   // configuration
   input wire logic i_narrow_bus,
   // opcode bytes from the prefetch queue
   input wire logic [7:0] i_byte,
   input wire logic i_byte_valid,
   output logic o_byte_ready,
   // decoded operation to the execution unit
   output arith_decode_pkg::dec_t o_dec,
   output logic o_dec_valid,
   input wire logic i_dec_ready,
   output logic o_dec_unsupported
);
   import arith_decode_pkg::*;

   typedef struct packed {
      state_t st;
      logic pend_valid;
      seg_t pend_seg;
      logic two_disp;
      logic two_imm;
      logic need_imm;
      dec_t rec;
   } core_t;

   core_t s_q;
   core_t s_d;
   logic take;
   logic [5:0] cost_min;
   logic [5:0] cost_max;

   // ****************************************************************
   // cycle budget
   // ****************************************************************
   arith_cost_lookup u_cost (
      .i_op(s_q.rec.op),
      .i_form(s_q.rec.form),
      .i_wide(s_q.rec.wide),
      .i_dir(s_q.rec.dir),
      .i_mem(s_q.rec.mem),
      .i_narrow_bus(i_narrow_bus),
      .o_cyc_min(cost_min),
      .o_cyc_max(cost_max)
   );

   // ****************************************************************
   // handshakes
   // ****************************************************************
   // no byte is taken while a record waits or its cost is formed
   assign o_byte_ready = (s_q.st != st_emit) && (s_q.st != st_cost);
   assign take = o_byte_ready && i_byte_valid;
   assign o_dec_valid = (s_q.st == st_emit);
   assign o_dec = s_q.rec;
   assign o_dec_unsupported = o_dec_valid && (s_q.rec.op == op_unsupported);

   // ****************************************************************
   // next state
   // ****************************************************************
   always_comb
   begin
      s_d = s_q;
      unique case (s_q.st)
         st_opcode:
         begin
            if (take)
            begin
               s_d.rec = '0;
               s_d.rec.wide = i_byte[0];
               s_d.rec.dir = i_byte[1];
               s_d.rec.seg_valid = s_q.pend_valid;
               s_d.rec.seg = s_q.pend_seg;
               s_d.two_disp = 1'b0;
               s_d.need_imm = 1'b0;
               s_d.two_imm = 1'b0;
               s_d.st = st_modrm;
               unique casez (i_byte)
                  8'b001?_?110:
                  begin
                     // prefix stands alone; it also arms the next record
                     s_d.rec.op = op_segment_prefix;
                     s_d.rec.form = form_single;
                     s_d.rec.wide = 1'b0;
                     s_d.rec.dir = 1'b0;
                     s_d.rec.seg_valid = 1'b1;
                     s_d.rec.seg = seg_t'(i_byte[4:3]);
                     s_d.pend_valid = 1'b1;
                     s_d.pend_seg = seg_t'(i_byte[4:3]);
                     s_d.st = st_cost;
                  end
                  8'b0000_00??:
                  begin
                     s_d.rec.op = op_sum;
                     s_d.rec.form = form_rm_reg;
                  end
                  8'b0001_00??:
                  begin
                     s_d.rec.op = op_sum_carry;
                     s_d.rec.form = form_rm_reg;
                  end
                  8'b0010_10??:
                  begin
                     s_d.rec.op = op_difference;
                     s_d.rec.form = form_rm_reg;
                  end
                  8'b0001_10??:
                  begin
                     s_d.rec.op = difference_with_borrow_op;
                     s_d.rec.form = form_rm_reg;
                  end
                  8'b0000_010?, 8'b0001_010?, 8'b0010_110?, 8'b0001_110?:
                  begin
                     unique case (i_byte[5:3])
                        3'h0: s_d.rec.op = op_sum;
                        3'h2: s_d.rec.op = op_sum_carry;
                        3'h5: s_d.rec.op = op_difference;
                        default:
                           s_d.rec.op = difference_with_borrow_op;
                     endcase
                     s_d.rec.form = form_imm_acc;
                     s_d.rec.dir = 1'b0;
                     s_d.need_imm = 1'b1;
                     s_d.two_imm = i_byte[0];
                     s_d.st = st_imm_lo;
                  end
                  8'b1000_00??:
                  begin
                     s_d.rec.form = form_imm_rm;
                     s_d.rec.sign = i_byte[1];
                     s_d.rec.dir = 1'b0;
                     s_d.need_imm = 1'b1;
                     s_d.two_imm = (i_byte[1:0] == 2'b01);
                  end
                  8'b1111_011?:
                  begin
                     s_d.rec.form = form_unary_rm;
                     s_d.rec.dir = 1'b0;
                  end
                  opc_unpacked_bcd_sum_adjust, opc_packed_bcd_sum_adjust,
                  opc_unpacked_bcd_difference_adjust,
                  opc_packed_bcd_difference_adjust:
                  begin
                     unique case (i_byte[4:3])
                        2'h2: s_d.rec.op = unpacked_bcd_sum_adjust;
                        2'h0: s_d.rec.op = packed_bcd_sum_adjust;
                        2'h3: s_d.rec.op =
                           unpacked_bcd_difference_adjust;
                        default: s_d.rec.op =
                           packed_bcd_difference_adjust;
                     endcase
                     s_d.rec.form = form_single;
                     s_d.rec.wide = 1'b0;
                     s_d.rec.dir = 1'b0;
                     s_d.st = st_cost;
                  end
                  default:
                  begin
                     // foreign opcode: reported alone, no operand bytes
                     s_d.rec.op = op_unsupported;
                     s_d.rec.form = form_single;
                     s_d.st = st_cost;
                  end
               endcase
            end
         end
         st_modrm:
         begin
            if (take)
            begin
               s_d.rec.mode = i_byte[7:6];
               s_d.rec.reg_fld = i_byte[5:3];
               s_d.rec.rm = i_byte[2:0];
               s_d.rec.mem = (i_byte[7:6] != mod_register);
               if (s_q.rec.form == form_imm_rm)
               begin
                  unique case (i_byte[5:3])
                     fld_sum: s_d.rec.op = op_sum;
                     fld_sum_carry: s_d.rec.op = op_sum_carry;
                     fld_difference: s_d.rec.op = op_difference;
                     fld_borrow:
                        s_d.rec.op = difference_with_borrow_op;
                     default: s_d.rec.op = op_unsupported;
                  endcase
               end
               else if (s_q.rec.form == form_unary_rm)
               begin
                  unique case (i_byte[5:3])
                     fld_sign_change: s_d.rec.op = sign_change_op;
                     fld_product: s_d.rec.op = unsigned_product_op;
                     default: s_d.rec.op = op_unsupported;
                  endcase
               end
               s_d.two_disp = (i_byte[7:6] == mod_disp16) ||
                  (i_byte[7:6] == mod_direct && i_byte[2:0] == rm_direct);
               if (i_byte[7:6] == mod_disp8 || s_d.two_disp)
                  s_d.st = st_disp_lo;
               else if (s_q.need_imm)
                  s_d.st = st_imm_lo;
               else
                  s_d.st = st_cost;
            end
         end
         st_disp_lo:
         begin
            if (take)
            begin
               s_d.rec.disp = {{8{i_byte[7]}}, i_byte};
               if (s_q.two_disp)
                  s_d.st = st_disp_hi;
               else
                  s_d.st = s_q.need_imm ? st_imm_lo : st_cost;
            end
         end
         st_disp_hi:
         begin
            if (take)
            begin
               s_d.rec.disp[15:8] = i_byte;
               s_d.st = s_q.need_imm ? st_imm_lo : st_cost;
            end
         end
         st_imm_lo:
         begin
            if (take)
            begin
               s_d.rec.imm = {8'h00, i_byte};
               if (s_q.rec.sign && s_q.rec.wide)
                  s_d.rec.imm[15:8] = {8{i_byte[7]}};
               s_d.st = s_q.two_imm ? st_imm_hi : st_cost;
            end
         end
         st_imm_hi:
         begin
            if (take)
            begin
               s_d.rec.imm[15:8] = i_byte;
               s_d.st = st_cost;
            end
         end
         st_cost:
         begin
            s_d.rec.cyc_min = cost_min;
            s_d.rec.cyc_max = cost_max;
            s_d.st = st_emit;
         end
         st_emit:
         begin
            if (i_dec_ready)
            begin
               // an override lives for exactly one following instruction
               if (s_q.rec.op != op_segment_prefix)
                  s_d.pend_valid = 1'b0;
               s_d.st = st_opcode;
            end
         end
      endcase
   end

   // ****************************************************************
   // state register
   // ****************************************************************
   always_ff @(posedge i_clock)
   begin
      if (!i_nrst)
         s_q <= '0;
      else
         s_q <= s_d;
   end

endmodule

// *** tb/arith_opcode_decoder_props.sv ***
// concurrent checks on the ports of the arithmetic opcode decoder
`timescale 1ns/1ps
module arith_opcode_decoder_props
   import arith_decode_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_nrst,
   input wire logic i_narrow_bus,
   input wire logic [7:0] i_byte,
   input wire logic i_byte_valid,
   input wire logic o_byte_ready,
   input wire arith_decode_pkg::dec_t o_dec,
   input wire logic o_dec_valid,
   input wire logic i_dec_ready,
   input wire logic o_dec_unsupported
);
   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (!i_nrst);
   logic fast;
   assign fast = o_dec_valid && !i_narrow_bus && o_dec.op != op_unsupported;

   // ****************************************************************
   // handshake
   // ****************************************************************
   AST_HOLD: assert property (o_dec_valid && !i_dec_ready |=>
      o_dec_valid && $stable(o_dec)) else $error("record changed");
   AST_TAKE: assert property (o_dec_valid && i_dec_ready |=>
      !o_dec_valid && o_byte_ready) else $error("record not retired");
   AST_REFUSE: assert property (o_dec_valid |-> !o_byte_ready)
      else $error("byte accepted while record offered");
   AST_ANSWER: assert property ($fell(o_byte_ready) |->
      !o_dec_valid ##1 o_dec_valid) else $error("record late");
   AST_UNSUP: assert property (o_dec_valid |-> o_dec_unsupported ==
      (o_dec.op == op_unsupported)) else $error("unsupported flag wrong");

   // ****************************************************************
   // cycle budgets and immediate sign extension
   // ****************************************************************
   AST_PREFIX: assert property (
      o_dec_valid && o_dec.op == op_segment_prefix |-> o_dec.seg_valid
      && o_dec.cyc_min == 6'h02 && o_dec.cyc_max == 6'h02)
      else $error("prefix record wrong");
   AST_SUM_ADJ: assert property (
      o_dec_valid && o_dec.op == unpacked_bcd_sum_adjust |->
      o_dec.cyc_min == 6'h08 && o_dec.cyc_max == 6'h08)
      else $error("unpacked sum adjust cost wrong");
   AST_DIFF_ADJ: assert property (
      o_dec_valid && o_dec.op == unpacked_bcd_difference_adjust |->
      o_dec.cyc_min == 6'h07 && o_dec.cyc_max == 6'h07)
      else $error("unpacked difference adjust cost wrong");
   AST_PACKED_ADJ: assert property (
      o_dec_valid && o_dec.op inside {packed_bcd_sum_adjust,
      packed_bcd_difference_adjust} |-> o_dec.cyc_min == 6'h04
      && o_dec.cyc_max == 6'h04) else $error("packed adjust cost wrong");
   AST_ACC: assert property (
      o_dec_valid && o_dec.form == form_imm_acc |-> !o_dec.mem &&
      o_dec.cyc_min == (o_dec.wide ? 6'h04 : 6'h03))
      else $error("accumulator cost wrong");
   AST_RM: assert property (
      fast && o_dec.form == form_rm_reg |->
      o_dec.cyc_min == (o_dec.mem ? 6'h0a : 6'h03))
      else $error("register form cost wrong");
   AST_IMM: assert property (
      fast && o_dec.form == form_imm_rm |-> o_dec.cyc_max ==
      o_dec.cyc_min && o_dec.cyc_min == (o_dec.mem ? 6'h10 : 6'h04))
      else $error("immediate form cost wrong");
   AST_NEG: assert property (
      fast && o_dec.op == sign_change_op |->
      o_dec.cyc_min == (o_dec.mem ? 6'h0a : 6'h03))
      else $error("sign change cost wrong");
   AST_PROD: assert property (
      fast && o_dec.op == unsigned_product_op |->
      o_dec.cyc_max == o_dec.cyc_min + 6'h02 && o_dec.cyc_min ==
      (o_dec.mem ? (o_dec.wide ? 6'h29 : 6'h20) :
      (o_dec.wide ? 6'h23 : 6'h1a))) else $error("product cost wrong");
   AST_NARROW: assert property (
      o_dec_valid && i_narrow_bus && o_dec.mem && o_dec.wide &&
      o_dec.op == unsigned_product_op |-> o_dec.cyc_min == 6'h2d)
      else $error("narrow bus word product cost wrong");
   AST_SEXT: assert property (
      o_dec_valid && o_dec.form == form_imm_rm && o_dec.sign &&
      o_dec.wide |-> o_dec.imm[15:8] == {8{o_dec.imm[7]}})
      else $error("immediate byte not sign extended");

   cover property (o_dec_valid && o_dec.op == op_segment_prefix);
   cover property (o_dec_valid && i_narrow_bus && o_dec.mem);
   cover property (o_dec_valid && !i_dec_ready);
   cover property (i_byte_valid && !o_byte_ready);
endmodule

bind arith_opcode_decoder arith_opcode_decoder_props u_props (
   .i_clock(i_clock), .i_nrst(i_nrst), .i_narrow_bus(i_narrow_bus),
   .i_byte(i_byte), .i_byte_valid(i_byte_valid),
   .o_byte_ready(o_byte_ready), .o_dec(o_dec),
   .o_dec_valid(o_dec_valid), .i_dec_ready(i_dec_ready),
   .o_dec_unsupported(o_dec_unsupported)
);

// *** tb/queue_exec_model.sv ***
// prefetch queue feeding bytes and execution unit taking records
`timescale 1ns/1ps
module queue_exec_model
   import arith_decode_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_slow,
   output logic [7:0] o_byte,
   output logic o_byte_valid,
   input wire logic i_byte_ready,
   input wire arith_decode_pkg::dec_t i_dec,
   input wire logic i_dec_valid,
   output logic o_dec_ready
);
   logic [7:0] bq[$];
   dec_t rq[$];
   logic phase;
   logic taken;
   initial
   begin
      o_byte = 8'h00;
      o_byte_valid = 1'b0;
      o_dec_ready = 1'b0;
      phase = 1'b0;
   end
   always @(posedge i_clock)
   begin
      taken = o_byte_valid && i_byte_ready;
      if (taken)
         bq.delete(0);
      if (i_dec_valid && o_dec_ready)
         rq.push_back(i_dec);
      #1;
      phase = ~phase;
      // an offered byte holds until taken; idle data toggles
      if (taken || !o_byte_valid)
      begin
         o_byte_valid = (bq.size() > 0) && !(i_slow && phase);
         o_byte = o_byte_valid ? bq[0] : ~o_byte;
      end
      o_dec_ready = !i_slow || phase;
   end
endmodule

// *** tb/tb_arith_opcode_decoder.sv ***
// self-checking bench for the arithmetic opcode decoder
`timescale 1ns/1ps
module tb_arith_opcode_decoder;
   import arith_decode_pkg::*;
   typedef struct {
      logic [39:0] b;
      int n;
      logic nb;
      op_t op;
      form_t fm;
      logic [1:0] wd;
      logic m;
      logic [2:0] sg;
      logic [15:0] xv;
      int mn;
      int mx;
   } row_t;
   localparam op_t borw = difference_with_borrow_op;
   localparam op_t negt = sign_change_op;
   localparam op_t prod = unsigned_product_op;
   localparam op_t pfx = op_segment_prefix;
   logic i_clock, i_nrst, i_narrow_bus, i_slow;
   logic [7:0] i_byte;
   logic i_byte_valid, o_byte_ready, o_dec_valid, i_dec_ready;
   logic o_dec_unsupported;
   dec_t o_dec, d;
   int err_count, total_checks, cycles;
   // bytes, count, narrow, op, form, {wide,dir}, mem, {seg ok,seg},
   // immediate or displacement, cost min, cost max
   row_t rows[] = '{
   '{40'h0405,2,0,op_sum,form_imm_acc,0,0,0,16'h0005,3,3},
   '{40'h053412,3,0,op_sum,form_imm_acc,2'h2,0,0,16'h1234,4,4},
   '{40'h03063412,4,0,op_sum,form_rm_reg,2'h3,1,0,16'h1234,10,10},
   '{40'h83c005,3,0,op_sum,form_imm_rm,2'h2,0,0,16'h0005,4,4},
   '{40'h12c1,2,0,op_sum_carry,form_rm_reg,2'h1,0,0,0,3,3},
   '{40'h8150803412,5,0,op_sum_carry,form_imm_rm,2'h2,1,0,16'h1234,16,16},
   '{40'h28c1,2,0,op_difference,form_rm_reg,0,0,0,0,3,3},
   '{40'h80e805,3,0,op_difference,form_imm_rm,0,0,0,16'h0005,4,4},
   '{40'h2d0102,3,0,op_difference,form_imm_acc,2'h2,0,0,16'h0201,4,4},
   '{40'h18c1,2,0,borw,form_rm_reg,0,0,0,0,3,3},
   '{40'h83d8ff,3,0,borw,form_imm_rm,2'h2,0,0,16'hffff,4,4},
   '{40'h1c09,2,0,borw,form_imm_acc,0,0,0,16'h0009,3,3},
   '{40'hf6d8,2,0,negt,form_unary_rm,0,0,0,0,3,3},
   '{40'hf71e0010,4,0,negt,form_unary_rm,2'h2,1,0,16'h1000,10,10},
   '{40'h37,1,0,unpacked_bcd_sum_adjust,form_single,0,0,0,0,8,8},
   '{40'h27,1,0,packed_bcd_sum_adjust,form_single,0,0,0,0,4,4},
   '{40'h3f,1,0,unpacked_bcd_difference_adjust,form_single,0,0,0,0,7,7},
   '{40'h2f,1,0,packed_bcd_difference_adjust,form_single,0,0,0,0,4,4},
   '{40'hf6e1,2,0,prod,form_unary_rm,0,0,0,0,26,28},
   '{40'hf7e1,2,0,prod,form_unary_rm,2'h2,0,0,0,35,37},
   '{40'hf6260020,4,0,prod,form_unary_rm,0,1,0,16'h2000,32,34},
   '{40'hf76610,3,0,prod,form_unary_rm,2'h2,1,0,16'h0010,41,43},
   '{40'h2e,1,0,pfx,form_single,0,0,3'h5,0,2,2},
   '{40'h37,1,0,unpacked_bcd_sum_adjust,form_single,0,0,3'h5,0,8,8},
   '{40'h27,1,0,packed_bcd_sum_adjust,form_single,0,0,0,0,4,4},
   '{40'h26,1,0,pfx,form_single,0,0,3'h4,0,2,2},
   '{40'h3e,1,0,pfx,form_single,0,0,3'h7,0,2,2},
   '{40'h2f,1,0,packed_bcd_difference_adjust,form_single,0,0,3'h7,0,4,4},
   '{40'h36,1,0,pfx,form_single,0,0,3'h6,0,2,2},
   '{40'hf6d8,2,0,negt,form_unary_rm,0,0,3'h6,0,3,3},
   '{40'hf71e0010,4,1,negt,form_unary_rm,2'h2,1,0,16'h1000,18,18},
   '{40'h03063412,4,1,op_sum,form_rm_reg,2'h3,1,0,16'h1234,14,14},
   '{40'h01063412,4,1,op_sum,form_rm_reg,2'h2,1,0,16'h1234,18,18},
   '{40'hf7260010,4,1,prod,form_unary_rm,2'h2,1,0,16'h1000,45,47},
   '{40'hf6260020,4,1,prod,form_unary_rm,0,1,0,16'h2000,32,34},
   '{40'h8306001005,5,1,op_sum,form_imm_rm,2'h2,1,0,16'h0005,24,24},
   '{40'h90,1,0,op_unsupported,form_single,0,0,0,0,0,0}};

   arith_opcode_decoder u_dut (.i_clock(i_clock), .i_nrst(i_nrst),
      .i_narrow_bus(i_narrow_bus), .i_byte(i_byte),
      .i_byte_valid(i_byte_valid), .o_byte_ready(o_byte_ready),
      .o_dec(o_dec), .o_dec_valid(o_dec_valid),
      .i_dec_ready(i_dec_ready), .o_dec_unsupported(o_dec_unsupported));
   queue_exec_model u_model (.i_clock(i_clock), .i_slow(i_slow),
      .o_byte(i_byte), .o_byte_valid(i_byte_valid),
      .i_byte_ready(o_byte_ready), .i_dec(o_dec),
      .i_dec_valid(o_dec_valid), .o_dec_ready(i_dec_ready));

   // ****************************************************************
   // helpers
   // ****************************************************************
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         err_count++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time,
            seen, exp);
      end
   endtask

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // feed one instruction and compare the record it yields
   task automatic run(input row_t r);
      int k;
      @(posedge i_clock);
      #1 i_narrow_bus = r.nb;
      @(negedge i_clock);
      for (k = r.n - 1; k >= 0; k--)
         u_model.bq.push_back(r.b[8*k +: 8]);
      k = 0;
      while (u_model.rq.size() == 0 && k < 300)
      begin
         @(negedge i_clock);
         k++;
      end
      if (u_model.rq.size() == 0)
      begin
         err_count++;
         return;
      end
      d = u_model.rq.pop_front();
      check({d.op, d.form, d.mem, d.seg_valid, d.seg & {2{d.seg_valid}}},
         {r.op, r.fm, r.m, r.sg});
      check({d.cyc_min, d.cyc_max},
         {6'(r.mn), 6'(r.mx)});
      check(u_model.bq.size(), 0);
      if (r.fm != form_single)
         check({d.wide, d.dir}, r.wd);
      if (r.fm inside {form_imm_rm, form_imm_acc})
         check(d.imm, r.xv);
      else if (r.m)
         check(d.disp, r.xv);
   endtask

   initial
   begin
      i_clock = 1'b0;
      forever #12.5 i_clock = ~i_clock;
   end

   always @(posedge i_clock)
   begin
      cycles++;
      if (cycles == 6000)
      begin
         err_count++;
         give_verdict();
      end
   end

   // ****************************************************************
   // sequence
   // ****************************************************************
   initial
   begin
      i_nrst = 1'b0;
      i_narrow_bus = 1'b0;
      i_slow = 1'b0;
      err_count = 0;
      total_checks = 0;
      cycles = 0;
      repeat (12) @(posedge i_clock);
      #1 check({o_byte_ready, o_dec_valid}, 2'h2);
      i_nrst = 1'b1;
      // second pass stalls both the byte feed and the record sink
      for (int p = 0; p < 2; p++)
      begin
         i_slow = p[0];
         foreach (rows[i])
            run(rows[i]);
      end
      // reset with a prefix pending and an instruction half taken
      @(negedge i_clock);
      u_model.bq.push_back(8'h26);
      u_model.bq.push_back(8'h81);
      while (u_model.bq.size() != 0)
         @(negedge i_clock);
      @(posedge i_clock);
      #1 i_nrst = 1'b0;
      repeat (2) @(posedge i_clock);
      #1 check({o_byte_ready, o_dec_valid}, 2'h2);
      i_nrst = 1'b1;
      u_model.rq.delete();
      run(rows[14]);
      give_verdict();
   end
endmodule
